//--- usb_function_control_pkg.sv
package usb_function_control_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int           ADDR_W          = 4;
	localparam logic [3:0]   LINK_CTRL_OFS   = 4'h0;
	localparam logic [3:0]   ID_SELECT_OFS   = 4'h1;
	localparam logic [3:0]   AUX_CTRL_OFS    = 4'h2;
	localparam logic [3:0]   CPU_CONFIG_OFS  = 4'h3;
	localparam logic [3:0]   RESET_STAT_OFS  = 4'h4;

	// ------------------------------------------------------------
	// Link control fields
	// ------------------------------------------------------------
	localparam int DIR_BIT     = 0;
	localparam int SETUP_BIT   = 1;
	localparam int POWER_BIT   = 2;
	localparam int WAKEEN_BIT  = 3;
	localparam int GATE_BIT    = 4;
	localparam int WAKEREQ_BIT = 5;
	localparam int RSV_BIT     = 6;
	localparam int ATTACH_BIT  = 7;
	localparam int PORTRST_BIT = 0;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic       GATE_RESET_DEF = 1'b0;
	localparam int         WAKE_PULSE_NS  = 1000;
	localparam int         CLK_PERIOD_NS  = 40;
	localparam int         WAKE_CYCLES    = WAKE_PULSE_NS / CLK_PERIOD_NS;

endpackage : usb_function_control_pkg

//--- por_only_reg.sv
`timescale 1ns/1ps
// Byte register loaded with RESET_VAL by the power-up reset only.
module por_only_reg #(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	// Clock and power-up reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Write port
	input  wire logic       wrEn,
	input  wire logic [7:0] wrMask,
	input  wire logic [7:0] wrData,
	// Contents
	output logic      [7:0] value
);

	logic [7:0] value_q;
	logic [7:0] value_d;

	assign value_d = wrEn ? ((value_q & ~wrMask) | (wrData & wrMask))
	                      : value_q;
	assign value   = value_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			value_q <= RESET_VAL;
		end else begin
			value_q <= value_d;
		end
	end

endmodule : por_only_reg

//--- wake_pulse_gen.sv
`timescale 1ns/1ps
// Fixed-length wake-up pulse; a request while busy is ignored.
module wake_pulse_gen #(
	parameter int CYCLES = usb_function_control_pkg::WAKE_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Request and pulse
	input  wire logic start,
	output logic      pulse
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;

	assign count_d = (start && count_q == '0) ? CW'(CYCLES)
	               : (count_q != '0) ? count_q - CW'(1) : count_q;
	assign pulse   = (count_q != '0);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

endmodule : wake_pulse_gen

//--- usb_function_control.sv
`timescale 1ns/1ps
// What this block does
// - Link control register clears only on power-up reset, not function reset.
// - Bit 0 sets data-stage direction: 0 OUT, 1 IN.
// - Bit 1 is firmware flag marking SETUP interrupt service.
// - Bit 2 read-only power source: 0 bus, 1 self powered.
// - Bit 3 holds remote wake-up enable written by firmware.
// - Bit 4 gates the USB function reset into internal reset.
// - Power-up value of gate bit is a build parameter, GATE_RESET.
// - Writing 1 to bit 5 starts wake pulse; bit self-clears; 0 ignored.
// - Bit 7 drives pullup pin high when set, low when clear.
// - Select status bits 3..0 show live pins; bits 7..4 read zero.
// - Selects 0,1 share port 3 bits 0,1; selects 2,3 dedicated.
// - Internal reset comes from power-up reset or gated function reset.
// - Internal reset clears only the port-reset flag; every other register resets on power-up reset alone.
// - CPU configuration register clears only on power-up reset.
// - Host port reset raises function reset; port-reset flag records it when gate bit 4 is clear.
module usb_function_control #(
	parameter logic GATE_RESET = usb_function_control_pkg::GATE_RESET_DEF,
	parameter int   WAKE_LEN   = usb_function_control_pkg::WAKE_CYCLES
) (
	// Clock and power-up reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Register port
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrStb,
	input  wire logic       rdStb,
	output logic      [7:0] rdData,
	// Upstream link
	input  wire logic       hostPortReset,
	output logic            pullupDrivePin,
	output logic            wakePulse,
	// Board straps and pins
	input  wire logic       selfPowered,
	input  wire logic [1:0] port3Pins,
	input  wire logic [1:0] selectPins,
	// Reset network
	output logic            internalReset
);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		return a == o;
	endfunction : hit

	wire linkWr = wrStb && hit(addr, usb_function_control_pkg::LINK_CTRL_OFS);
	wire auxWr  = wrStb && hit(addr, usb_function_control_pkg::AUX_CTRL_OFS);
	wire cfgWr  = wrStb && hit(addr, usb_function_control_pkg::CPU_CONFIG_OFS);
	wire rstWr  = wrStb && hit(addr, usb_function_control_pkg::RESET_STAT_OFS);

	// ------------------------------------------------------------
	// Power-up-only registers
	// ------------------------------------------------------------
	logic [7:0] linkCtrl;
	logic [7:0] auxCtrl;
	logic [7:0] cpuCfg;
	logic       wakeBusy;

	// Writable link bits; read-only and self-clearing bits are masked out.
	localparam logic [7:0] LINK_WR_MASK = 8'h9b;
	localparam logic [7:0] LINK_RESET   = {3'h0, GATE_RESET, 4'h0};

	por_only_reg #(
		.RESET_VAL (LINK_RESET)
	) u_link (
		.clk    (clk),
		.rst    (rst),
		.wrEn   (linkWr),
		.wrMask (LINK_WR_MASK),
		.wrData (wrData),
		.value  (linkCtrl)
	);

	por_only_reg #(
		.RESET_VAL (usb_function_control_pkg::REG_RESET)
	) u_aux (
		.clk    (clk),
		.rst    (rst),
		.wrEn   (auxWr),
		.wrMask (8'hff),
		.wrData (wrData),
		.value  (auxCtrl)
	);

	por_only_reg #(
		.RESET_VAL (usb_function_control_pkg::REG_RESET)
	) u_cfg (
		.clk    (clk),
		.rst    (rst),
		.wrEn   (cfgWr),
		.wrMask (8'hff),
		.wrData (wrData),
		.value  (cpuCfg)
	);

	// ------------------------------------------------------------
	// Reset network
	// ------------------------------------------------------------
	// gate function reset
	assign internalReset = rst ||
		(hostPortReset && linkCtrl[usb_function_control_pkg::GATE_BIT]);

	// cleared by internal reset
	// The flag survives a gated function reset only when the gate is off,
	// so firmware can still see a port reset it chose not to act on.
	logic portRstFlag_q;
	logic portRstFlag_d;
	assign portRstFlag_d = hostPortReset ? 1'b1
		: (rstWr && wrData[usb_function_control_pkg::PORTRST_BIT]) ? 1'b0
		: portRstFlag_q;

	always_ff @(posedge clk or posedge internalReset) begin
		if (internalReset) begin
			portRstFlag_q <= 1'b0;
		end else begin
			portRstFlag_q <= portRstFlag_d;
		end
	end

	// ------------------------------------------------------------
	// Remote wake-up
	// ------------------------------------------------------------
	// write one starts pulse
	wire wakeStart = linkWr && wrData[usb_function_control_pkg::WAKEREQ_BIT];

	wake_pulse_gen #(
		.CYCLES (WAKE_LEN)
	) u_wake (
		.clk   (clk),
		.rst   (rst),
		.start (wakeStart),
		.pulse (wakeBusy)
	);

	assign wakePulse = wakeBusy;

	// ------------------------------------------------------------
	// Pins and read-back
	// ------------------------------------------------------------
	// pullup follows attach bit
	assign pullupDrivePin = linkCtrl[usb_function_control_pkg::ATTACH_BIT];

	wire [7:0] linkView = {linkCtrl[7], 1'b0, wakeBusy, linkCtrl[4:3],
	                       selfPowered, linkCtrl[1:0]};

	wire [7:0] selView = {4'h0, selectPins, port3Pins};

	wire [7:0] rdMux =
		hit(addr, usb_function_control_pkg::LINK_CTRL_OFS)  ? linkView :
		hit(addr, usb_function_control_pkg::ID_SELECT_OFS)  ? selView  :
		hit(addr, usb_function_control_pkg::AUX_CTRL_OFS)   ? auxCtrl  :
		hit(addr, usb_function_control_pkg::CPU_CONFIG_OFS) ? cpuCfg   :
		hit(addr, usb_function_control_pkg::RESET_STAT_OFS) ?
			{7'h0, portRstFlag_q} : 8'h00;

	logic [7:0] rdData_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData_q <= 8'h00;
		end else begin
			rdData_q <= rdStb ? rdMux : 8'h00;
		end
	end
	assign rdData = rdData_q;

endmodule : usb_function_control

//--- usb_function_control_checker.sv
`timescale 1ns/1ps
module usb_function_control_checker #(
	parameter logic GATE_RESET = 1'b0,
	parameter int   WAKE_LEN   = 3
) (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wrData,
	input wire logic       wrStb,
	input wire logic       rdStb,
	input wire logic [7:0] rdData,
	// Link and pins
	input wire logic       hostPortReset,
	input wire logic       pullupDrivePin,
	input wire logic       wakePulse,
	input wire logic       selfPowered,
	input wire logic [1:0] port3Pins,
	input wire logic [1:0] selectPins,
	input wire logic       internalReset
);
	logic [7:0] linkQ;
	int         runQ;
	wire        linkWr = wrStb && addr == 4'h0;
	wire        linkRd = rdStb && addr == 4'h0;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// The shadow ignores the port reset, as the real register must.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			linkQ <= {3'h0, GATE_RESET, 4'h0};
			runQ  <= 0;
		end else begin
			if (linkWr) linkQ <= wrData;
			runQ <= wakePulse ? runQ + 1 : 0;
		end
	end
	pullup_follow_a:
	assert property (linkWr |=> pullupDrivePin == $past(wrData[7]))
		else $error("pullup level wrong");
	wake_start_a:
	assert property (linkWr && !wakePulse && !internalReset
		|=> wakePulse == $past(wrData[5])) else $error("wake start wrong");
	wake_len_a:
	assert property ($fell(wakePulse) |-> runQ == WAKE_LEN)
		else $error("wake pulse length wrong");
	reset_gate_a:
	assert property (internalReset == (hostPortReset && linkQ[4]))
		else $error("internal reset wrong");
	idle_read_a:
	assert property (!$past(rdStb) |-> rdData == 8'h00)
		else $error("read data outside slot");
	link_keep_a:
	assert property (linkRd |=> (rdData & 8'h9b) == ($past(linkQ) & 8'h9b))
		else $error("link bits lost");
	status_bits_a:
	assert property (linkRd |=> rdData[6:5] == {1'b0, $past(wakePulse)}
		&& rdData[2] == $past(selfPowered)) else $error("status bits wrong");
	select_read_a:
	assert property (rdStb && addr == 4'h1 |=> rdData ==
		{4'h0, $past(selectPins), $past(port3Pins)})
		else $error("select read wrong");
endmodule : usb_function_control_checker
bind usb_function_control usb_function_control_checker #(
	.GATE_RESET(GATE_RESET), .WAKE_LEN(WAKE_LEN)) chk (.clk(clk),
	.rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
	.rdStb(rdStb), .rdData(rdData), .hostPortReset(hostPortReset),
	.pullupDrivePin(pullupDrivePin), .wakePulse(wakePulse),
	.selfPowered(selfPowered), .port3Pins(port3Pins),
	.selectPins(selectPins), .internalReset(internalReset));

//--- usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
	// Clock
	input  wire logic clk,
	// Upstream link
	input  wire logic pullupDrivePin,
	input  wire logic wakePulse,
	output logic      hostPortReset
);
	int wakeSeen = 0;
	initial hostPortReset = 1'b0;
	task automatic portReset(input int n);
		@(posedge clk);
		hostPortReset <= pullupDrivePin;
		repeat (n) @(posedge clk);
		hostPortReset <= 1'b0;
	endtask : portReset
	always @(posedge wakePulse) wakeSeen++;
endmodule : usb_host_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wrData = 8'h00;
	logic       wrStb = 1'b0;
	logic       rdStb = 1'b0;
	logic       selfPowered = 1'b1;
	logic [1:0] port3Pins = 2'h0;
	logic [1:0] selectPins = 2'h0;
	logic [7:0] rdData;
	logic       hostPortReset, pullupDrivePin, wakePulse, internalReset;
	int         errors = 0;
	int         samplesChecked = 0;
	always #20 clk = ~clk;
	usb_function_control #(.WAKE_LEN(3)) DUT (.clk(clk), .rst(rst),
		.addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
		.rdData(rdData), .hostPortReset(hostPortReset),
		.pullupDrivePin(pullupDrivePin), .wakePulse(wakePulse),
		.selfPowered(selfPowered), .port3Pins(port3Pins),
		.selectPins(selectPins), .internalReset(internalReset));
	usb_host_model host (.clk(clk), .pullupDrivePin(pullupDrivePin),
		.wakePulse(wakePulse), .hostPortReset(hostPortReset));
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] got, exp, input string what);
		samplesChecked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1 check(rdData, e, "read");
	endtask : rd
	task automatic close_out();
		$display("errors=%0d checked=%0d", errors, samplesChecked);
		if (errors == 0 && samplesChecked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_link();
		rd(4'h0, 8'h04);
		wr(4'h0, 8'hdb);
		check(pullupDrivePin, 8'h01, "pullup on");
		rd(4'h0, 8'h9f);
		@(posedge clk) selfPowered <= 1'b0;
		rd(4'h0, 8'h9b);
		@(posedge clk) selfPowered <= 1'b1;
		wr(4'h0, 8'h00);
		check(pullupDrivePin, 8'h00, "pullup off");
		rd(4'h0, 8'h04);
	endtask : t_link
	task automatic t_wake();
		wr(4'h0, 8'h20);
		check(wakePulse, 8'h01, "wake on");
		rd(4'h0, 8'h24);
		repeat (3) @(posedge clk);
		rd(4'h0, 8'h04);
		check(8'(host.wakeSeen), 8'h01, "wake count");
	endtask : t_wake
	task automatic t_select();
		for (int i = 0; i < 16; i++) begin
			@(posedge clk) {selectPins, port3Pins} <= 4'(i);
			rd(4'h1, 8'(i));
		end
		rd(4'hf, 8'h00);
	endtask : t_select
	task automatic t_freset(input logic [7:0] v);
		wr(4'h2, 8'h5a);
		wr(4'h3, 8'ha5);
		wr(4'h0, v);
		fork
			host.portReset(4);
			begin
				repeat (2) @(posedge clk);
				#1 check(internalReset, 8'(v[4]), "gate");
			end
		join
		rd(4'h0, v | 8'h04);
		rd(4'h2, 8'h5a);
		rd(4'h3, 8'ha5);
		rd(4'h4, {7'h0, ~v[4]});
		wr(4'h4, 8'h01);
		rd(4'h4, 8'h00);
	endtask : t_freset
	// A power-up reset in mid-run must clear the link, auxiliary and CPU configuration registers.
	task automatic t_por();
		wr(4'h0, 8'h9b);
		@(posedge clk) rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(4'h0, 8'h04);
		rd(4'h2, 8'h00);
		rd(4'h3, 8'h00);
	endtask : t_por
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_link();
		t_wake();
		t_select();
		t_freset(8'h8b);
		t_freset(8'h9b);
		t_por();
		close_out();
	end
	initial begin
		#100000;
		errors++;
		close_out();
	end
endmodule : testbench
